// File: rtl/ltsel_params.svh
// Constants for the latency tolerance selector: offsets, fields, timing
// Functional notes
// [R1] Idle state reports idle field for link speed
// [R2] Active state reports active field for speed
// [R3] Power-up values come from loaded image, else zero
// [R4] USB or lite reset restores image values
// [R5] Load countdown when enabled and all idle
// [R6] Countdown reaching zero enters idle state
// [R7] Each count is one 100 us tick
// [R8] Gigabit reload from first register upper half
// [R9] 100 Mbps reload from first register lower half
// [R10] 10 Mbps reload from second register lower half
// [R11] Activity stops countdown, returns to active state
`ifndef LTSEL_PARAMS_SVH
`define LTSEL_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define LTSEL_OFF_IDLE0   8'he0
`define LTSEL_OFF_IDLE1   8'he4
`define LTSEL_OFF_ACT0    8'he8
`define LTSEL_OFF_ACT1    8'hec
`define LTSEL_OFF_INACT0  8'hf0
`define LTSEL_OFF_INACT1  8'hf4
`define LTSEL_OFF_CTRL    8'hf8
`define LTSEL_OFF_STAT    8'hfc

// ****************************************
// Field positions
// ****************************************
`define LTSEL_TOL_HI_LSB  16
`define LTSEL_TOL_W       12
`define LTSEL_RLD_HI_LSB  16
`define LTSEL_RLD_W       16

// ****************************************
// Masks of writable bits per register
// ****************************************
`define LTSEL_MASK_TOL2   32'h0fff_0fff
`define LTSEL_MASK_TOL1   32'h0000_0fff
`define LTSEL_MASK_RLD2   32'hffff_ffff
`define LTSEL_MASK_RLD1   32'h0000_ffff
`define LTSEL_MASK_CTRL   32'h0000_0001

// ****************************************
// Timing
// ****************************************
`define LTSEL_CLK_MHZ     125
`define LTSEL_TICK_US     100
`define LTSEL_TICK_CYC    (`LTSEL_TICK_US * `LTSEL_CLK_MHZ)

`endif

// File: rtl/ltsel_pkg.sv
// Types shared by the latency tolerance selector
package ltsel_pkg;

  // Ethernet link speed code
  typedef enum logic [1:0] {
    LTSEL_SPD_10   = 2'h0,
    LTSEL_SPD_100  = 2'h1,
    LTSEL_SPD_1000 = 2'h2
  } ltsel_speed_t;

  // Latency state, one-hot
  typedef enum logic [1:0] {
    LTSEL_ST_ACTIVE = 2'h1,
    LTSEL_ST_IDLE   = 2'h2
  } ltsel_state_t;

  // Image defaults for all six registers
  typedef struct packed {
    logic [31:0] idle0;
    logic [31:0] idle1;
    logic [31:0] act0;
    logic [31:0] act1;
    logic [31:0] inact0;
    logic [31:0] inact1;
  } ltsel_image_t;

  // Activity sources of the data path
  typedef struct packed {
    logic up_fifo_empty;
    logic down_fifo_empty;
    logic rx_fifo_empty;
    logic tx_fifo_empty;
    logic bulk_out_pending;
  } ltsel_activity_t;

endpackage

// File: rtl/ltsel_top.sv
// Latency tolerance selector with Wishbone register file
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "ltsel_params.svh"

module ltsel_top #(
  parameter int unsigned TICK_CYC = `LTSEL_TICK_CYC  // Cycles per 100 us tick
) (
  input  wire logic                      clk_i,        // 125 MHz clock
  input  wire logic                      rst_i,        // Sync reset, high
  input  wire logic                      usb_reset_i,  // USB reset pulse
  input  wire logic                      lite_reset_i, // Lite reset pulse
  input  wire logic                      image_valid_i,// Image load strobe
  input  wire ltsel_pkg::ltsel_image_t   image_i,      // Loaded image data
  input  wire ltsel_pkg::ltsel_speed_t   speed_i,      // Link speed
  input  wire ltsel_pkg::ltsel_activity_t act_i,       // Data path activity
  input  wire logic                      wb_cyc_i,     // Wishbone cycle
  input  wire logic                      wb_stb_i,     // Wishbone strobe
  input  wire logic                      wb_we_i,      // Write enable
  input  wire logic [7:0]                wb_adr_i,     // Byte address
  input  wire logic [3:0]                wb_sel_i,     // Byte selects
  input  wire logic [31:0]               wb_dat_i,     // Write data
  output logic      [31:0]               wb_dat_o,     // Read data
  output logic                           wb_ack_o,     // Acknowledge
  output logic      [11:0]               tol_o,        // Reported tolerance
  output logic                           idle_o        // In idle state
);

  // ****************************************
  // Declarations
  // ****************************************
  ltsel_pkg::ltsel_image_t img_q;        // Last loaded image
  ltsel_pkg::ltsel_image_t reg_q;        // Live register file
  ltsel_pkg::ltsel_state_t st_q;         // Latency state
  logic                    en_q;         // Latency messaging enable
  logic [15:0]             cnt_q;        // Inactivity countdown
  logic                    run_q;        // Countdown running
  logic [31:0]             pre_q;        // 100 us prescaler
  logic                    tick;         // Prescaler tick
  logic                    quiet;        // All FIFOs empty, none pending
  logic                    wr;           // Write strobe
  logic [31:0]             rdata;        // Read mux
  logic [15:0]             reload;       // Speed-selected reload
  logic [11:0]             tol_sel;      // Speed/state selected tolerance
  logic [15:0]             tol_pick;     // Selected 16-bit field before trim
  logic                    restore;      // Restore to image

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge = res & mask;
  endfunction

  // Pick a field by link speed from pair register and single register
  function automatic logic [15:0] pick(input ltsel_pkg::ltsel_speed_t spd,
                                       input logic [31:0] pair,
                                       input logic [31:0] single);
    case (spd)
      ltsel_pkg::LTSEL_SPD_1000: pick = pair[`LTSEL_RLD_HI_LSB +: 16];
      ltsel_pkg::LTSEL_SPD_100:  pick = pair[15:0];
      default:                   pick = single[15:0];
    endcase
  endfunction

  assign restore = usb_reset_i | lite_reset_i;
  assign wr      = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign quiet   = act_i.up_fifo_empty & act_i.down_fifo_empty &
                   act_i.rx_fifo_empty & act_i.tx_fifo_empty &
                   ~act_i.bulk_out_pending;
  // Reload follows link speed
  assign reload  = pick(speed_i, reg_q.inact0, reg_q.inact1); // [R8] [R9] [R10]

  // ****************************************
  // Image capture
  // ****************************************
  // Holds the most recent EEPROM or OTP image, zero when none loaded
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      img_q <= '0; // [R3]
    end else if (image_valid_i) begin
      img_q <= image_i; // [R3]
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  // Image load, reset restore, then software writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_q <= '0;
    end else if (image_valid_i) begin
      reg_q.idle0  <= image_i.idle0  & `LTSEL_MASK_TOL2; // [R3]
      reg_q.idle1  <= image_i.idle1  & `LTSEL_MASK_TOL1;
      reg_q.act0   <= image_i.act0   & `LTSEL_MASK_TOL2;
      reg_q.act1   <= image_i.act1   & `LTSEL_MASK_TOL1;
      reg_q.inact0 <= image_i.inact0 & `LTSEL_MASK_RLD2;
      reg_q.inact1 <= image_i.inact1 & `LTSEL_MASK_RLD1;
    end else if (restore) begin
      reg_q.idle0  <= img_q.idle0  & `LTSEL_MASK_TOL2; // [R4]
      reg_q.idle1  <= img_q.idle1  & `LTSEL_MASK_TOL1;
      reg_q.act0   <= img_q.act0   & `LTSEL_MASK_TOL2;
      reg_q.act1   <= img_q.act1   & `LTSEL_MASK_TOL1;
      reg_q.inact0 <= img_q.inact0 & `LTSEL_MASK_RLD2;
      reg_q.inact1 <= img_q.inact1 & `LTSEL_MASK_RLD1;
    end else if (wr) begin
      case (wb_adr_i)
        `LTSEL_OFF_IDLE0:  begin
          reg_q.idle0 <= merge(reg_q.idle0, wb_dat_i, wb_sel_i, `LTSEL_MASK_TOL2);
        end
        `LTSEL_OFF_IDLE1:  begin
          reg_q.idle1 <= merge(reg_q.idle1, wb_dat_i, wb_sel_i, `LTSEL_MASK_TOL1);
        end
        `LTSEL_OFF_ACT0:   begin
          reg_q.act0 <= merge(reg_q.act0, wb_dat_i, wb_sel_i, `LTSEL_MASK_TOL2);
        end
        `LTSEL_OFF_ACT1:   begin
          reg_q.act1 <= merge(reg_q.act1, wb_dat_i, wb_sel_i, `LTSEL_MASK_TOL1);
        end
        `LTSEL_OFF_INACT0: begin
          reg_q.inact0 <= merge(reg_q.inact0, wb_dat_i, wb_sel_i, `LTSEL_MASK_RLD2);
        end
        `LTSEL_OFF_INACT1: begin
          reg_q.inact1 <= merge(reg_q.inact1, wb_dat_i, wb_sel_i, `LTSEL_MASK_RLD1);
        end
        default: begin
          // Other offsets hold no tolerance data
        end
      endcase
    end
  end

  // Enable bit, cleared by every reset
  always_ff @(posedge clk_i) begin
    if (rst_i || restore) begin
      en_q <= 1'b0;
    end else if (wr && wb_adr_i == `LTSEL_OFF_CTRL && wb_sel_i[0]) begin
      en_q <= wb_dat_i[0];
    end
  end

  // ****************************************
  // Wishbone answer
  // ****************************************
  // Read mux; unmapped offsets read zero
  always_comb begin
    case (wb_adr_i)
      `LTSEL_OFF_IDLE0:  rdata = reg_q.idle0;
      `LTSEL_OFF_IDLE1:  rdata = reg_q.idle1;
      `LTSEL_OFF_ACT0:   rdata = reg_q.act0;
      `LTSEL_OFF_ACT1:   rdata = reg_q.act1;
      `LTSEL_OFF_INACT0: rdata = reg_q.inact0;
      `LTSEL_OFF_INACT1: rdata = reg_q.inact1;
      `LTSEL_OFF_CTRL:   rdata = {31'h0, en_q};
      `LTSEL_OFF_STAT:   rdata = {cnt_q, 14'h0, run_q, idle_o};
      default:           rdata = 32'h0;
    endcase
  end

  // One-cycle ack, every access answered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rdata;
    end
  end

  // ****************************************
  // 100 us prescaler
  // ****************************************
  // Restarts with each countdown load so ticks are whole periods
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_q) begin
      pre_q <= 32'h0;
    end else if (pre_q == TICK_CYC - 1) begin
      pre_q <= 32'h0; // [R7]
    end else begin
      pre_q <= pre_q + 32'h1;
    end
  end
  assign tick = run_q && (pre_q == TICK_CYC - 1); // [R7]

  // ****************************************
  // Inactivity countdown and state
  // ****************************************
  // Load on quiet, count on ticks, leave on activity
  always_ff @(posedge clk_i) begin
    if (rst_i || restore) begin
      st_q  <= ltsel_pkg::LTSEL_ST_ACTIVE;
      run_q <= 1'b0;
      cnt_q <= 16'h0;
    end else begin
      case (st_q)
        ltsel_pkg::LTSEL_ST_ACTIVE: begin
          if (!en_q || !quiet) begin
            run_q <= 1'b0; // [R11]
            cnt_q <= 16'h0;
          end else if (!run_q) begin
            run_q <= 1'b1; // [R5]
            cnt_q <= reload; // [R5]
            if (reload == 16'h0) begin
              st_q  <= ltsel_pkg::LTSEL_ST_IDLE; // [R6]
              run_q <= 1'b0;
            end
          end else if (tick) begin
            cnt_q <= cnt_q - 16'h1; // [R6]
            if (cnt_q <= 16'h1) begin
              st_q  <= ltsel_pkg::LTSEL_ST_IDLE; // [R6]
              run_q <= 1'b0;
              cnt_q <= 16'h0;
            end
          end
        end
        ltsel_pkg::LTSEL_ST_IDLE: begin
          if (!en_q || !quiet) begin
            st_q <= ltsel_pkg::LTSEL_ST_ACTIVE; // [R11]
          end
        end
        default: begin
          st_q <= ltsel_pkg::LTSEL_ST_ACTIVE;
        end
      endcase
    end
  end

  // ****************************************
  // Tolerance output
  // ****************************************
  // Field chosen by state and speed, trimmed to the tolerance width
  always_comb begin
    if (st_q == ltsel_pkg::LTSEL_ST_IDLE) begin
      tol_pick = pick(speed_i, reg_q.idle0, reg_q.idle1); // [R1]
    end else begin
      tol_pick = pick(speed_i, reg_q.act0, reg_q.act1); // [R2]
    end
    tol_sel = tol_pick[11:0]; // Upper nibble is reserved and reads zero
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tol_o  <= 12'h0;
      idle_o <= 1'b0;
    end else begin
      tol_o  <= tol_sel; // [R1] [R2]
      idle_o <= (st_q == ltsel_pkg::LTSEL_ST_IDLE);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Tolerance reported for each state and speed
  chk_idle_tol_out: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (st_q == ltsel_pkg::LTSEL_ST_IDLE && speed_i == ltsel_pkg::LTSEL_SPD_100)
    |=> tol_o == $past(reg_q.idle0[11:0]))
    else $error("idle tolerance not reported");
  chk_idle_gig: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (st_q == ltsel_pkg::LTSEL_ST_IDLE && speed_i == ltsel_pkg::LTSEL_SPD_1000)
    |=> tol_o == $past(reg_q.idle0[27:16]))
    else $error("idle gigabit tolerance wrong");
  chk_active_fast: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (st_q == ltsel_pkg::LTSEL_ST_ACTIVE && speed_i == ltsel_pkg::LTSEL_SPD_100)
    |=> tol_o == $past(reg_q.act0[11:0]))
    else $error("active fast tolerance wrong");
  chk_active_slow: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (st_q == ltsel_pkg::LTSEL_ST_ACTIVE && speed_i == ltsel_pkg::LTSEL_SPD_10)
    |=> tol_o == $past(reg_q.act1[11:0]))
    else $error("active slow tolerance wrong");
  chk_active_gig: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (st_q == ltsel_pkg::LTSEL_ST_ACTIVE && speed_i == ltsel_pkg::LTSEL_SPD_1000)
    |=> tol_o == $past(reg_q.act0[27:16]))
    else $error("active gigabit tolerance wrong");
  chk_idle_slow: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (st_q == ltsel_pkg::LTSEL_ST_IDLE && speed_i == ltsel_pkg::LTSEL_SPD_10)
    |=> tol_o == $past(reg_q.idle1[11:0]))
    else $error("idle slow tolerance wrong");
  chk_image_load: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    image_valid_i |=> reg_q.inact0 == $past(image_i.inact0))
    else $error("image not loaded");
  chk_restore_img: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (restore && !image_valid_i) |=> reg_q.inact1 == ($past(img_q.inact1) & 32'h0000_ffff))
    else $error("restore failed");
  chk_load_gig: assert property (@(posedge clk_i) disable iff (rst_i || restore) // [R8]
    (st_q == ltsel_pkg::LTSEL_ST_ACTIVE && en_q && quiet && !run_q &&
     speed_i == ltsel_pkg::LTSEL_SPD_1000) |=> cnt_q == $past(reg_q.inact0[31:16]))
    else $error("gigabit reload wrong");
  chk_tick_gap: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    tick |=> !tick)
    else $error("prescaler ticks too often");
  chk_zero_idle: assert property (@(posedge clk_i) disable iff (rst_i || restore) // [R6]
    (run_q && tick && cnt_q == 16'h1 && en_q && quiet)
    |=> st_q == ltsel_pkg::LTSEL_ST_IDLE)
    else $error("no idle entry at zero");
  chk_activity_exit: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (st_q == ltsel_pkg::LTSEL_ST_IDLE && !quiet) |=> st_q == ltsel_pkg::LTSEL_ST_ACTIVE)
    else $error("activity did not wake");
  chk_no_run_busy: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    !quiet |=> !run_q)
    else $error("countdown runs while busy");
  chk_restore_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    restore |=> (st_q == ltsel_pkg::LTSEL_ST_ACTIVE && !run_q && !en_q))
    else $error("reset did not stop countdown");

  // Countdown load per speed, start and zero reload
  chk_load_fast: assert property (@(posedge clk_i) disable iff (rst_i || restore) // [R9]
    (st_q == ltsel_pkg::LTSEL_ST_ACTIVE && en_q && quiet && !run_q &&
     speed_i == ltsel_pkg::LTSEL_SPD_100) |=> cnt_q == $past(reg_q.inact0[15:0]))
    else $error("fast reload wrong");
  chk_load_slow: assert property (@(posedge clk_i) disable iff (rst_i || restore) // [R10]
    (st_q == ltsel_pkg::LTSEL_ST_ACTIVE && en_q && quiet && !run_q &&
     speed_i == ltsel_pkg::LTSEL_SPD_10) |=> cnt_q == $past(reg_q.inact1[15:0]))
    else $error("slow reload wrong");
  chk_load_run: assert property (@(posedge clk_i) disable iff (rst_i || restore) // [R5]
    (st_q == ltsel_pkg::LTSEL_ST_ACTIVE && en_q && quiet && !run_q && reload != 16'h0)
    |=> run_q && cnt_q == $past(reload))
    else $error("countdown not started");
  chk_zero_reload: assert property (@(posedge clk_i) disable iff (rst_i || restore) // [R6]
    (st_q == ltsel_pkg::LTSEL_ST_ACTIVE && en_q && quiet && !run_q && reload == 16'h0)
    |=> st_q == ltsel_pkg::LTSEL_ST_IDLE)
    else $error("zero reload did not enter idle");

  // ****************************************
  // Covers
  // ****************************************
  // Idle entry, wake, reset restore and zero reload
  cov_idle_entry: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_q == ltsel_pkg::LTSEL_ST_IDLE));
  cov_wake: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(st_q == ltsel_pkg::LTSEL_ST_IDLE));
  cov_restore: cover property (@(posedge clk_i) disable iff (rst_i) restore);
  cov_zero_reload: cover property (@(posedge clk_i) disable iff (rst_i)
    st_q == ltsel_pkg::LTSEL_ST_ACTIVE && en_q && quiet && !run_q && reload == 16'h0);

endmodule

// File: dv/ltsel_host_model.sv
// Host side model that keeps the last reported latency tolerance
`timescale 1ns/1ps

module ltsel_host_model (
  input  wire logic        clk_i,      // Bench clock
  input  wire logic        rst_i,      // Sync reset, high
  input  wire logic [11:0] tol_i,      // Reported tolerance
  input  wire logic        idle_i,     // Device idle flag
  output logic      [11:0] last_tol_o, // Last message value
  output logic      [31:0] n_msg_o     // Messages received
);
  // ****************************************
  // Message capture
  // ****************************************
  // A new message is seen whenever the reported value or state moves
  logic        idle_q; // Previous idle flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_tol_o <= 12'h000;
      idle_q     <= 1'b0;
      n_msg_o    <= 32'h0;
    end else if (tol_i !== last_tol_o || idle_i !== idle_q) begin
      last_tol_o <= tol_i;
      idle_q     <= idle_i;
      n_msg_o    <= n_msg_o + 32'h1;
    end
  end
endmodule

// File: dv/tb_top.sv
// Self-checking bench of the latency tolerance selector
`timescale 1ns/1ps
`include "ltsel_params.svh"

module tb_top;
  // ****************************************
  // Signals and bench state
  // ****************************************
  localparam int T = 10; // Short tick for simulation
  logic clk_i, rst_i, usb_r, lite_r, img_v, cyc, stb, we, ack;
  logic [7:0]  adr;      // Bus address
  logic [3:0]  sel, bsel; // Byte lanes on the bus, lanes wanted next
  logic [31:0] dat, rdat, seed, q;
  logic [11:0] tol, htol; // Design and host view
  logic        idle;     // Idle flag
  logic [31:0] hmsg;     // Host message count
  ltsel_pkg::ltsel_image_t    img;  // Image handed in
  ltsel_pkg::ltsel_speed_t    spd;  // Link speed
  ltsel_pkg::ltsel_activity_t act;  // Activity sources
  logic [31:0] e[6], ie[6], m[6];   // Expected, image, masks
  int n_errors, n_compared;
  localparam logic [4:0] QUIET = 5'h1e; // All empty, none pending

  ltsel_top #(.TICK_CYC(T)) u_ltsel_top (
    .clk_i(clk_i), .rst_i(rst_i), .usb_reset_i(usb_r), .lite_reset_i(lite_r),
    .image_valid_i(img_v), .image_i(img), .speed_i(spd), .act_i(act),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tol_o(tol), .idle_o(idle));

  ltsel_host_model u_ltsel_host_model (
    .clk_i(clk_i), .rst_i(rst_i), .tol_i(tol), .idle_i(idle),
    .last_tol_o(htol), .n_msg_o(hmsg));

  // ****************************************
  // Helpers
  // ****************************************
  // Pseudo random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected tolerance from state and speed
  function automatic logic [31:0] texp(input bit idl, input int s);
    int b;
    b = idl ? 0 : 2;
    if (s == 2) return {20'h0, e[b][27:16]};
    if (s == 1) return {20'h0, e[b][11:0]};
    return {20'h0, e[b+1][11:0]};
  endfunction

  // Expected reload from speed
  function automatic int rexp(input int s);
    if (s == 2) return int'(e[4][31:16]);
    if (s == 1) return int'(e[4][15:0]);
    return int'(e[5][15:0]);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle, held until ack sampled
  task automatic wb(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    sel <= bsel;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) chk(32'h1, 32'h0);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  // Read back all six registers
  task automatic check_regs;
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'he0 + 8'(i * 4), 32'h0);
      chk(q, e[i]);
    end
  endtask

  // Count cycles from quiet to idle, then check tolerance
  task automatic wait_idle(input int s);
    int c, n;
    c = 0;
    n = rexp(s);
    act <= QUIET;
    while (idle !== 1'b1 && c < 2000) begin
      @(posedge clk_i);
      c++;
    end
    // Load edge, n ticks of T, output register and sampling lag
    chk(32'(c), 32'(n * T + 3));
    repeat (2) @(posedge clk_i);
    chk({20'h0, tol}, texp(1'b1, s));
    chk({20'h0, htol}, texp(1'b1, s));
    wb(1'b0, `LTSEL_OFF_STAT, 32'h0);
    chk(q, 32'h0000_0001);
  endtask

  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  initial begin
    #(8 * 20000);
    n_errors++;
    finish_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_i = 1'b1; usb_r = 1'b0; lite_r = 1'b0; img_v = 1'b0; cyc = 1'b0;
    stb = 1'b0; we = 1'b0; adr = 8'h0; dat = 32'h0; img = '0;
    spd = ltsel_pkg::LTSEL_SPD_1000; act = 5'h01; seed = 32'h24bc;
    n_errors = 0; n_compared = 0;
    sel = 4'hf; bsel = 4'hf;
    m = '{`LTSEL_MASK_TOL2, `LTSEL_MASK_TOL1, `LTSEL_MASK_TOL2,
          `LTSEL_MASK_TOL1, `LTSEL_MASK_RLD2, `LTSEL_MASK_RLD1};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Random image load
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      img[32 * (5 - i) +: 32] <= seed;
      e[i] = seed & m[i];
      ie[i] = e[i];
    end
    @(posedge clk_i);
    img_v <= 1'b1;
    @(posedge clk_i);
    img_v <= 1'b0;
    check_regs();
    wb(1'b0, 8'h80, 32'h0);
    chk(q, 32'h0);
    // Random tolerances, short reloads
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wb(1'b1, 8'he0 + 8'(i * 4), seed);
      e[i] = seed & m[i];
    end
    wb(1'b1, 8'hf0, 32'h0003_0002);
    wb(1'b1, 8'hf4, 32'h0005_0004);
    e[4] = 32'h0003_0002;
    e[5] = 32'h0000_0004;
    // Single byte lane write leaves the other lanes alone
    bsel = 4'h4;
    wb(1'b1, 8'he0, 32'hffff_ffff);
    bsel = 4'hf;
    e[0] = ((e[0] & 32'hff00_ffff) | 32'h00ff_0000) & m[0];
    check_regs();
    // Active state per speed
    for (int s = 0; s < 3; s++) begin
      spd <= ltsel_pkg::ltsel_speed_t'(s);
      repeat (3) @(posedge clk_i);
      chk({20'h0, tol}, texp(1'b0, s));
    end
    // Enable, then each speed reaches idle
    wb(1'b1, 8'hf8, 32'h1);
    for (int s = 2; s >= 0; s--) begin
      act <= 5'h01;
      spd <= ltsel_pkg::ltsel_speed_t'(s);
      repeat (3) @(posedge clk_i);
      wait_idle(s);
      // Every activity source wakes the device
      for (int i = 0; i < 5; i++) begin
        act <= QUIET ^ 5'(1 << i);
        repeat (3) @(posedge clk_i);
        chk({31'h0, idle}, 32'h0);
        chk({20'h0, tol}, texp(1'b0, s));
        wait_idle(s);
      end
    end
    // Zero reload enters idle on the first quiet edge
    wb(1'b1, 8'hf4, 32'h0);
    e[5] = 32'h0;
    act <= 5'h01;
    repeat (3) @(posedge clk_i);
    wait_idle(0);
    // USB reset, then lite reset, restore the image
    for (int r = 0; r < 2; r++) begin
      wb(1'b1, 8'he8, 32'h0123_0456);
      @(posedge clk_i);
      usb_r <= (r == 0);
      lite_r <= (r == 1);
      @(posedge clk_i);
      usb_r <= 1'b0;
      lite_r <= 1'b0;
      e = ie;
      check_regs();
      repeat (60) @(posedge clk_i);
      chk({31'h0, idle}, 32'h0);
      chk({20'h0, tol}, texp(1'b0, 0));
      wb(1'b0, 8'hf8, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, 8'hf8, 32'h1);
    end
    chk(32'(hmsg > 0), 32'h1);
    finish_test();
  end
endmodule
